/* File: design/mat_pkg.sv */
/*
  Constants, modes and states of the motor constant auto-tune sequencer.
  Assumes a single 100 MHz control clock.
*/
package mat_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 100000000;
  localparam int unsigned STAT_MIN_S      = 25;
  localparam int unsigned STAT_MAX_S      = 120;
  localparam int unsigned ROT_BASE_S      = 40;
  localparam int unsigned ROT_EXTRA_S     = 30;
  localparam int unsigned TICK_CYC        = 100000;   // 1 ms tick
  localparam int unsigned MS_PER_S        = CLK_HZ / TICK_CYC;
  localparam int unsigned STAT_MIN_MS     = STAT_MIN_S * 1000;
  localparam int unsigned STAT_MAX_MS     = STAT_MAX_S * 1000;
  localparam int unsigned ROT_EXTRA_MS    = ROT_EXTRA_S * 1000;

  // ----------------------------------------------------------------
  // Tuning mode parameter codes
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_OFF      = 8'h00;
  localparam logic [7:0] MODE_STAT     = 8'h01;   // 1
  localparam logic [7:0] MODE_STAT_RUN = 8'h02;   // 2
  localparam logic [7:0] MODE_STAT_OK  = 8'h03;   // 3
  localparam logic [7:0] MODE_ROT      = 8'h65;   // 101
  localparam logic [7:0] MODE_ROT_RUN  = 8'h66;   // 102
  localparam logic [7:0] MODE_ROT_OK   = 8'h67;   // 103

  // ----------------------------------------------------------------
  // Error codes and converter voltage limit
  // ----------------------------------------------------------------
  localparam logic [7:0] ERR_NONE   = 8'h00;
  localparam logic [7:0] ERR_FORCED = 8'h08;
  localparam logic [7:0] ERR_TRIP   = 8'h09;
  localparam logic [7:0] ERR_ILIM   = 8'h5B;   // 91
  localparam logic [7:0] ERR_VOLT   = 8'h5C;   // 92
  localparam logic [7:0] ERR_CALC   = 8'h5D;   // 93
  localparam logic [7:0] VOLT_PCT   = 8'h4B;   // 75 % of rated

  // ----------------------------------------------------------------
  // Motor type codes and parameter defaults
  // ----------------------------------------------------------------
  localparam logic [7:0]  MOTOR_VEC_A   = 8'h21;    // 33
  localparam logic [7:0]  MOTOR_VEC_B   = 8'h22;    // 34
  localparam logic [15:0] FREQ_DEF_HZ   = 16'h003C; // 60 Hz
  localparam logic [15:0] VOLT_DEF_V    = 16'h00C8; // 200 V class

  typedef enum logic [2:0] {
    MAT_IDLE, MAT_RUN, MAT_DONE, MAT_ERR, MAT_WAIT_REL
  } mat_state_t;
endpackage : mat_pkg

/* File: design/mat_const_store.sv */
/*
  Holds the measured motor constants as parameters.
  Assumes the sequencer writes only on a successful end.
*/
`timescale 1ns/10ps
module mat_const_store #(
  parameter int unsigned W = 16,
  parameter int unsigned N = 4
) (
  input  wire logic                 sys_clk,
  input  wire logic                 nrst,
  input  wire logic                 wr_en,
  input  wire logic [N*W-1:0]       wr_data,
  input  wire logic                 invalidate,
  output logic      [N*W-1:0]       rd_data,
  output logic                      valid
);
  logic [N*W-1:0] mem_r;
  logic [N*W-1:0] mem_nxt;
  logic           valid_r;
  logic           valid_nxt;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  always_comb begin
    mem_nxt   = mem_r;
    valid_nxt = valid_r;
    if (wr_en) begin
      mem_nxt   = wr_data;
      valid_nxt = 1'b1;
    end else if (invalidate) begin
      valid_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      mem_r   <= '0;
      valid_r <= 1'b0;
    end else begin
      mem_r   <= mem_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign rd_data = mem_r;
  assign valid   = valid_r;
endmodule : mat_const_store

/* File: design/mat_autotune.sv */
/*
  Motor constant auto-tune sequencer: start, abort, status, error codes.
  Assumes synchronous inputs from the panel, the start lines and the
  power stage, which does the measurement and reports results and faults.
*/
`timescale 1ns/10ps
module mat_autotune #(
  parameter int unsigned CW         = 16,
  parameter int unsigned NC         = 4,
  parameter int unsigned TICK_DIV   = mat_pkg::TICK_CYC,
  parameter int unsigned STAT_MS    = mat_pkg::STAT_MIN_MS,
  parameter int unsigned STAT_MAXMS = mat_pkg::STAT_MAX_MS,
  parameter int unsigned EXTRA_MS   = mat_pkg::ROT_EXTRA_MS
) (
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic              mode_wr,
  input  wire logic [7:0]        mode_wdata,
  input  wire logic [7:0]        motor_type_param,
  input  wire logic [15:0]       motor_volt_param,
  input  wire logic [15:0]       motor_freq_param,
  input  wire logic [15:0]       accel_ms,
  input  wire logic [15:0]       decel_ms,
  input  wire logic [15:0]       set_freq_in,
  input  wire logic              fwd_key,
  input  wire logic              rev_key,
  input  wire logic              stop_key,
  input  wire logic              fwd_start_input,
  input  wire logic              rev_start_input,
  input  wire logic              output_stop_input,
  input  wire logic              fault_clear_input,
  input  wire logic              second_set_select,
  input  wire logic              overheat_input,
  input  wire logic              select_input,
  input  wire logic              other_inputs_active,
  input  wire logic              meas_done,
  input  wire logic [NC*CW-1:0]  meas_data,
  input  wire logic              prot_trip,
  input  wire logic              cur_limit,
  input  wire logic [7:0]        dc_volt_pct,
  input  wire logic              calc_err,
  input  wire logic              power_fail,
  input  wire logic              retry_cfg,
  output logic [7:0]             tuning_mode_param,
  output logic [7:0]             error_code,
  output logic                   run_out,
  output logic                   rotate_en,
  output logic                   meas_en,
  output logic                   pre_excite_en,
  output logic                   retry_en,
  output logic                   io_gate,
  output logic                   second_set_out,
  output logic [15:0]            set_freq_mon,
  output logic [15:0]            rated_freq,
  output logic [15:0]            rated_volt,
  output logic                   use_builtin,
  output logic [NC*CW-1:0]       const_data,
  output logic                   const_valid,
  output logic                   busy
);
  // ----------------------------------------------------------------
  // Millisecond tick divider
  // ----------------------------------------------------------------
  logic [31:0] div_r, div_nxt;
  logic        tick;

  always_comb begin
    tick    = (div_r == 32'(TICK_DIV - 1));
    div_nxt = tick ? 32'h0000_0000 : div_r + 32'h0000_0001;
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) div_r <= '0;
    else       div_r <= div_nxt;
  end

  // ----------------------------------------------------------------
  // Mode decoding
  // ----------------------------------------------------------------
  function automatic logic mode_is_rot(input logic [7:0] m);
    return (m == mat_pkg::MODE_ROT);
  endfunction : mode_is_rot

  // Only the two request codes arm a run; done codes must be rewritten first
  function automatic logic mode_is_set(input logic [7:0] m);
    return (m == mat_pkg::MODE_STAT) || (m == mat_pkg::MODE_ROT);
  endfunction : mode_is_set

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  mat_pkg::mat_state_t st_r, st_nxt;
  logic [7:0]  mode_r, mode_nxt;
  logic [7:0]  err_r, err_nxt;
  logic        rot_r, rot_nxt;
  logic [31:0] ms_r, ms_nxt;
  logic [31:0] lim_r, lim_nxt;
  logic        st_prev_r, st_prev_nxt;
  logic        wr_const, inval;
  logic        start_req, start_held, abort_req;
  logic        mode_armed;

  // Any start line or key; panel key and line are not told apart here
  assign start_req  = fwd_key | rev_key | fwd_start_input | rev_start_input;
  assign start_held = fwd_start_input | rev_start_input;
  assign mode_armed = mode_is_set(mode_r);

  // Start release counts only for the line mode; keys are momentary
  assign abort_req = output_stop_input | fault_clear_input | stop_key
                   | (st_prev_r & ~start_held);

  always_comb begin
    st_nxt      = st_r;
    mode_nxt    = mode_r;
    err_nxt     = err_r;
    rot_nxt     = rot_r;
    ms_nxt      = ms_r;
    lim_nxt     = lim_r;
    st_prev_nxt = st_prev_r;
    wr_const    = 1'b0;
    inval       = 1'b0;
    case (st_r)
      mat_pkg::MAT_IDLE: begin
        if (mode_wr) begin
          mode_nxt = mode_wdata;
          inval    = 1'b1;
        end else if (mode_armed && start_req) begin
          rot_nxt     = mode_is_rot(mode_r);
          mode_nxt    = mode_is_rot(mode_r) ? mat_pkg::MODE_ROT_RUN
                                            : mat_pkg::MODE_STAT_RUN;
          ms_nxt      = '0;
          st_prev_nxt = start_held;
          // Rotating time follows the ramps; stationary has a fixed ceiling
          lim_nxt     = mode_is_rot(mode_r)
                      ? 32'(accel_ms) + 32'(decel_ms) + 32'(EXTRA_MS)
                      : 32'(STAT_MAXMS);
          st_nxt      = mat_pkg::MAT_RUN;
        end
      end
      mat_pkg::MAT_RUN: begin
        if (tick) ms_nxt = ms_r + 32'h0000_0001;
        if (power_fail || prot_trip) begin
          err_nxt = mat_pkg::ERR_TRIP;
          st_nxt  = mat_pkg::MAT_ERR;
        end else if (abort_req) begin
          err_nxt = mat_pkg::ERR_FORCED;
          st_nxt  = mat_pkg::MAT_ERR;
        end else if (cur_limit) begin
          err_nxt = mat_pkg::ERR_ILIM;
          st_nxt  = mat_pkg::MAT_ERR;
        end else if (dc_volt_pct >= mat_pkg::VOLT_PCT) begin
          err_nxt = mat_pkg::ERR_VOLT;
          st_nxt  = mat_pkg::MAT_ERR;
        end else if (calc_err || (ms_r >= lim_r)) begin
          err_nxt = mat_pkg::ERR_CALC;
          st_nxt  = mat_pkg::MAT_ERR;
        end else if (meas_done && (rot_r || ms_r >= 32'(STAT_MS))) begin
          wr_const = 1'b1;
          mode_nxt = rot_r ? mat_pkg::MODE_ROT_OK : mat_pkg::MODE_STAT_OK;
          st_nxt   = mat_pkg::MAT_DONE;
        end
      end
      mat_pkg::MAT_DONE: begin
        // A key start has no line to release, so it waits for the stop key
        if (stop_key || (st_prev_r && !start_held)) begin
          st_nxt = mat_pkg::MAT_WAIT_REL;
        end
      end
      mat_pkg::MAT_WAIT_REL: begin
        if (!start_held) st_nxt = mat_pkg::MAT_IDLE;
      end
      mat_pkg::MAT_ERR: begin
        // Only a drive reset leaves this state
        st_nxt = mat_pkg::MAT_ERR;
      end
      default: st_nxt = mat_pkg::MAT_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_r      <= mat_pkg::MAT_IDLE;
      mode_r    <= mat_pkg::MODE_OFF;
      err_r     <= mat_pkg::ERR_NONE;
      rot_r     <= 1'b0;
      ms_r      <= '0;
      lim_r     <= '0;
      st_prev_r <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      mode_r    <= mode_nxt;
      err_r     <= err_nxt;
      rot_r     <= rot_nxt;
      ms_r      <= ms_nxt;
      lim_r     <= lim_nxt;
      st_prev_r <= st_prev_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Constant store
  // ----------------------------------------------------------------
  mat_const_store #(.W(CW), .N(NC)) u_store (
    .sys_clk    (sys_clk),
    .nrst       (nrst),
    .wr_en      (wr_const),
    .wr_data    (meas_data),
    .invalidate (inval),
    .rd_data    (const_data),
    .valid      (const_valid)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign busy              = (st_r == mat_pkg::MAT_RUN);
  assign tuning_mode_param = mode_r;
  assign error_code        = err_r;
  assign run_out           = busy;
  assign meas_en           = busy;
  assign rotate_en         = busy & rot_r;
  assign pre_excite_en     = ~(mode_armed | busy);
  assign retry_en          = retry_cfg & ~busy;
  // Unlisted functions are gated off while tuning runs
  assign io_gate           = busy & other_inputs_active;
  // Held input is honoured; toggling it mid-run is the operator's fault
  assign second_set_out    = second_set_select & ~overheat_input & ~select_input | busy & second_set_select;
  assign set_freq_mon      = busy ? 16'h0000 : set_freq_in;
  assign use_builtin       = (motor_type_param == mat_pkg::MOTOR_VEC_A) ||
                             (motor_type_param == mat_pkg::MOTOR_VEC_B);
  assign rated_freq        = (motor_freq_param == 16'h0000) ? mat_pkg::FREQ_DEF_HZ
                                                            : motor_freq_param;
  assign rated_volt        = (motor_volt_param == 16'h0000) ? mat_pkg::VOLT_DEF_V
                                                            : motor_volt_param;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_run_on_start: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st_r == mat_pkg::MAT_IDLE && mode_armed && start_req && !mode_wr) |=> run_out)
    else $error("run output not on at tuning start");
  a_abort_forced: assert property (@(posedge sys_clk) disable iff (!nrst)
    (busy && abort_req && !power_fail && !prot_trip) |=> error_code == mat_pkg::ERR_FORCED)
    else $error("abort did not give forced end code");
  a_done_mode: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st_r != mat_pkg::MAT_DONE ##1 st_r == mat_pkg::MAT_DONE) |->
    (tuning_mode_param == (rot_r ? mat_pkg::MODE_ROT_OK : mat_pkg::MODE_STAT_OK)))
    else $error("wrong mode code after success");
  a_err_sticky: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st_r == mat_pkg::MAT_ERR) |=> (st_r == mat_pkg::MAT_ERR) && !run_out)
    else $error("error state left without reset");
  a_err_no_write: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st_r == mat_pkg::MAT_ERR) |=> $stable(const_data))
    else $error("constants changed after error");
  a_freq_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
    busy |-> set_freq_mon == 16'h0000)
    else $error("set frequency monitor not zero");
  a_preexc_off: assert property (@(posedge sys_clk) disable iff (!nrst)
    (tuning_mode_param == mat_pkg::MODE_STAT || tuning_mode_param == mat_pkg::MODE_ROT
     || busy) |-> !pre_excite_en)
    else $error("pre-excitation enabled while tuning");
  a_pfail_err: assert property (@(posedge sys_clk) disable iff (!nrst)
    (busy && power_fail) |=> (error_code == mat_pkg::ERR_TRIP) ##1 !busy)
    else $error("power failure did not end tuning");
  a_no_retry: assert property (@(posedge sys_clk) disable iff (!nrst)
    busy |-> !retry_en)
    else $error("retry allowed during tuning");
  a_status_run: assert property (@(posedge sys_clk) disable iff (!nrst)
    busy |-> (tuning_mode_param == (rot_r ? mat_pkg::MODE_ROT_RUN : mat_pkg::MODE_STAT_RUN)))
    else $error("wrong status code while tuning");
  a_key_done_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st_r == mat_pkg::MAT_DONE && !st_prev_r && !stop_key) |=> st_r == mat_pkg::MAT_DONE)
    else $error("key started run cleared without stop key");
  a_mode_locked: assert property (@(posedge sys_clk) disable iff (!nrst)
    (mode_wr && st_r != mat_pkg::MAT_IDLE && st_r != mat_pkg::MAT_RUN)
    |=> $stable(tuning_mode_param))
    else $error("mode written outside idle");
  a_volt_code: assert property (@(posedge sys_clk) disable iff (!nrst)
    (busy && !power_fail && !prot_trip && !abort_req && !cur_limit
     && dc_volt_pct >= mat_pkg::VOLT_PCT) |=> error_code == mat_pkg::ERR_VOLT)
    else $error("converter voltage limit gave wrong code");
endmodule : mat_autotune

/* File: testbench/mat_panel_model.sv */
/*
  Operator panel keys and external start lines facing the tuning sequencer.
  Assumes the bench calls its tasks; every change lands 1 ns after a rising edge.
*/
`timescale 1ns/10ps
module mat_panel_model (
  input  wire logic sys_clk,
  output logic      fwd_key,
  output logic      rev_key,
  output logic      stop_key,
  output logic      fwd_start_input,
  output logic      rev_start_input,
  output logic      second_set_select
);
  // ----------------------------------------------------------------
  // Operator actions
  // ----------------------------------------------------------------
  // Second set select never moves while tuning runs
  initial begin
    fwd_key           = 1'b0;
    rev_key           = 1'b0;
    stop_key          = 1'b0;
    fwd_start_input   = 1'b0;
    rev_start_input   = 1'b0;
    second_set_select = 1'b0;
  end

  // One-edge key press; 0 forward, 1 reverse, 2 stop
  task automatic press(input int k);
    @(posedge sys_clk);
    #1;
    fwd_key  = (k == 0);
    rev_key  = (k == 1);
    stop_key = (k == 2);
    @(posedge sys_clk);
    #1;
    fwd_key  = 1'b0;
    rev_key  = 1'b0;
    stop_key = 1'b0;
  endtask : press

  // Start line level; returns one edge later so the sequencer has seen it
  task automatic line(input int d, input logic on);
    @(posedge sys_clk);
    #1;
    if (d == 0) fwd_start_input = on;
    else rev_start_input = on;
    @(posedge sys_clk);
    #1;
  endtask : line

  // Set only between runs; it must hold while tuning runs
  task automatic set_rt(input logic v);
    @(posedge sys_clk);
    #1;
    second_set_select = v;
  endtask : set_rt
endmodule : mat_panel_model

/* File: testbench/mat_autotune_tb_top.sv */
/*
  Self-checking bench of the tuning sequencer, with the panel model.
  Assumes shortened tick and duration parameters; inputs move 1 ns after an edge.
*/
`timescale 1ns/10ps
module mat_autotune_tb_top;
  localparam int unsigned TDIV = 10;
  localparam int unsigned SMS  = 5;
  localparam int unsigned SMAX = 50;
  localparam int unsigned XMS  = 20;
  logic        sys_clk = 1'b0, nrst = 1'b0, mode_wr = 1'b0, meas_done = 1'b0;
  logic [7:0]  mode_wdata = 8'h00, motor_type_param = 8'h00, dc_volt_pct = 8'h00;
  logic [15:0] motor_volt_param = 16'h0000, motor_freq_param = 16'h0000, set_freq_in = 16'h0000;
  logic [15:0] accel_ms = 16'h0002, decel_ms = 16'h0002;
  logic        output_stop_input = 1'b0, fault_clear_input = 1'b0, overheat_input = 1'b0;
  logic        select_input = 1'b0, other_inputs_active = 1'b0, retry_cfg = 1'b0;
  logic        prot_trip = 1'b0, cur_limit = 1'b0, calc_err = 1'b0, power_fail = 1'b0;
  logic [63:0] meas_data = 64'h0, const_data;
  logic        fwd_key, rev_key, stop_key, fwd_start_input, rev_start_input, second_set_select;
  logic [7:0]  tuning_mode_param, error_code;
  logic        run_out, rotate_en, meas_en, pre_excite_en, retry_en, io_gate, second_set_out;
  logic [15:0] set_freq_mon, rated_freq, rated_volt;
  logic        use_builtin, const_valid, busy;
  int          failures = 0;
  int          total_checks = 0;
  int          seed = 32'hB908;
  logic [63:0] held_q[$];
  logic [7:0]  err_tab [11] = '{8'h08, 8'h08, 8'h08, 8'h08, 8'h09, 8'h09, 8'h5B, 8'h5C,
                                8'h5D, 8'h5D, 8'h5D};

  always #5 sys_clk = ~sys_clk;

  mat_panel_model i_panel (.sys_clk(sys_clk), .fwd_key(fwd_key), .rev_key(rev_key),
    .stop_key(stop_key), .fwd_start_input(fwd_start_input), .rev_start_input(rev_start_input),
    .second_set_select(second_set_select));

  mat_autotune #(.TICK_DIV(TDIV), .STAT_MS(SMS), .STAT_MAXMS(SMAX), .EXTRA_MS(XMS)) i_dut (
    .sys_clk(sys_clk), .nrst(nrst), .mode_wr(mode_wr), .mode_wdata(mode_wdata),
    .motor_type_param(motor_type_param), .motor_volt_param(motor_volt_param),
    .motor_freq_param(motor_freq_param), .accel_ms(accel_ms), .decel_ms(decel_ms),
    .set_freq_in(set_freq_in), .fwd_key(fwd_key), .rev_key(rev_key), .stop_key(stop_key),
    .fwd_start_input(fwd_start_input), .rev_start_input(rev_start_input),
    .output_stop_input(output_stop_input), .fault_clear_input(fault_clear_input),
    .second_set_select(second_set_select), .overheat_input(overheat_input),
    .select_input(select_input), .other_inputs_active(other_inputs_active),
    .meas_done(meas_done), .meas_data(meas_data), .prot_trip(prot_trip),
    .cur_limit(cur_limit), .dc_volt_pct(dc_volt_pct), .calc_err(calc_err),
    .power_fail(power_fail), .retry_cfg(retry_cfg), .tuning_mode_param(tuning_mode_param),
    .error_code(error_code), .run_out(run_out), .rotate_en(rotate_en), .meas_en(meas_en),
    .pre_excite_en(pre_excite_en), .retry_en(retry_en), .io_gate(io_gate),
    .second_set_out(second_set_out), .set_freq_mon(set_freq_mon), .rated_freq(rated_freq),
    .rated_volt(rated_volt), .use_builtin(use_builtin), .const_data(const_data),
    .const_valid(const_valid), .busy(busy));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  // Bounded wait for the end of a run
  task automatic wait_idle(input int lim, output int n);
    n = 0;
    while (busy !== 1'b0 && n < lim) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n >= lim) begin
      failures++;
      test_done();
    end
  endtask : wait_idle

  task automatic write_mode(input logic [7:0] m);
    @(posedge sys_clk);
    #1;
    mode_wr    = 1'b1;
    mode_wdata = m;
    @(posedge sys_clk);
    #1;
    mode_wr    = 1'b0;
  endtask : write_mode

  // Error end is left only by a reset, so each error case starts from one
  task automatic err_case(input int c);
    int n;
    int dur;
    int d;
    d = (c == 10) ? 1 : 0;
    @(posedge sys_clk);
    #1;
    nrst = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    nrst = 1'b1;
    write_mode((c == 10) ? mat_pkg::MODE_ROT : mat_pkg::MODE_STAT);
    i_panel.line(d, 1'b1);
    repeat (3) @(posedge sys_clk);
    #1;
    case (c)
      0: output_stop_input = 1'b1;
      1: fault_clear_input = 1'b1;
      2: i_panel.press(2);
      3: i_panel.line(0, 1'b0);
      4: prot_trip = 1'b1;
      5: power_fail = 1'b1;
      6: cur_limit = 1'b1;
      7: begin
        dc_volt_pct = 8'h4A;
        repeat (4) @(posedge sys_clk);
        #1;
        chk(busy, 1'b1);
        dc_volt_pct = 8'h4B;
      end
      8: calc_err = 1'b1;
      default: ;
    endcase
    wait_idle(SMAX * TDIV + 60, n);
    {output_stop_input, fault_clear_input, prot_trip, power_fail, cur_limit, calc_err} = 6'h00;
    dc_volt_pct = 8'h00;
    chk(error_code, err_tab[c]);
    chk(const_valid, 1'b0);
    chk(tuning_mode_param === mat_pkg::MODE_STAT_OK, 1'b0);
    dur = (c == 10) ? (4 + XMS) * TDIV : SMAX * TDIV;
    if (c >= 9) chk((n + 5 >= dur - TDIV) && (n + 5 <= dur + 2 * TDIV), 1'b1);
    i_panel.press(0);
    chk(busy, 1'b0);
    i_panel.line(d, 1'b0);
  endtask : err_case

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int n;
    repeat (12) @(posedge sys_clk);
    #1;
    nrst = 1'b1;
    chk(tuning_mode_param, 8'h00);
    chk(pre_excite_en, 1'b1);
    chk(rated_freq, 16'h003C);
    chk(rated_volt, mat_pkg::VOLT_DEF_V);
    motor_freq_param = 16'h0032;
    motor_volt_param = 16'h00E6;
    for (int t = 32; t < 36; t++) begin
      motor_type_param = t[7:0];
      @(posedge sys_clk);
      #1;
      chk(use_builtin, (t == 33 || t == 34));
    end
    chk(rated_freq, 16'h0032);
    $display("test defaults done");
    retry_cfg           = 1'b1;
    other_inputs_active = 1'b1;
    overheat_input      = 1'b1;
    select_input        = 1'b1;
    i_panel.set_rt(1'b1);
    set_freq_in         = $random(seed);
    write_mode(mat_pkg::MODE_STAT);
    chk(pre_excite_en, 1'b0);
    i_panel.line(0, 1'b1);
    chk({busy, run_out, rotate_en}, 3'h6);
    chk(tuning_mode_param, mat_pkg::MODE_STAT_RUN);
    chk({set_freq_mon, retry_en, io_gate}, 18'h00001);
    chk(second_set_out, 1'b1);
    meas_data = {$random(seed), $random(seed)};
    meas_done = 1'b1;
    @(posedge sys_clk);
    #1;
    meas_done = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(busy, 1'b1);
    repeat (SMS * TDIV + 2 * TDIV) @(posedge sys_clk);
    #1;
    meas_data = {$random(seed), $random(seed)};
    held_q.push_back(meas_data);
    meas_done = 1'b1;
    wait_idle(20, n);
    meas_done = 1'b0;
    chk(tuning_mode_param, mat_pkg::MODE_STAT_OK);
    chk({const_valid, const_data}, {1'b1, held_q[$]});
    meas_data = {$random(seed), $random(seed)};
    i_panel.press(0);
    chk({busy, tuning_mode_param}, {1'b0, mat_pkg::MODE_STAT_OK});
    i_panel.line(0, 1'b0);
    chk(const_data, held_q[$]);
    $display("test stationary done");
    write_mode(mat_pkg::MODE_ROT);
    chk(const_valid, 1'b0);
    i_panel.press(1);
    chk({busy, rotate_en, tuning_mode_param}, {2'h3, mat_pkg::MODE_ROT_RUN});
    repeat (5) @(posedge sys_clk);
    #1;
    meas_data = {$random(seed), $random(seed)};
    held_q.push_back(meas_data);
    meas_done = 1'b1;
    wait_idle(20, n);
    meas_done = 1'b0;
    chk(tuning_mode_param, mat_pkg::MODE_ROT_OK);
    chk(const_data, held_q[$]);
    i_panel.press(1);
    chk(busy, 1'b0);
    write_mode(mat_pkg::MODE_ROT);
    chk(tuning_mode_param, mat_pkg::MODE_ROT_OK);
    i_panel.press(2);
    write_mode(mat_pkg::MODE_STAT);
    chk(tuning_mode_param, mat_pkg::MODE_STAT);
    $display("test rotating done");
    for (int c = 0; c < 11; c++) err_case(c);
    $display("test errors done");
    test_done();
  end
endmodule : mat_autotune_tb_top
